// ---- verification/rsa_core_chk.sv ----
/* Concurrent checks on the ports of rsa_core.
   Assumes it is bound onto rsa_core and sees only its ports. */
`timescale 1ns/1ps
module rsa_core_chk #(
   parameter CS_DIV = 8
) (
   input wire        ref_clk_in,
   input wire        rst_in,
   input wire        psel_in,
   input wire        penable_in,
   input wire        pwrite_in,
   input wire [7:0]  paddr_in,
   input wire [31:0] pwdata_in,
   input wire [31:0] prdata_out,
   input wire        pready_out,
   input wire        pslverr_out,
   input wire        shutdown_wake_in,
   input wire        clk_in_shutdown_in,
   input wire        dbg_halt_in,
   input wire        irq_out,
   input wire        wake_out,
   input wire        evt_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   // An access phase held by the slave.
   sequence stall_s;
      psel_in && penable_in && !pready_out;
   endsequence
   // First access cycle of a counter or calendar read.
   sequence cnt_rd_s;
      psel_in && $rose(penable_in) && !pwrite_in && (paddr_in == 8'h20 || paddr_in == 8'h24);
   endsequence
   // Completing cycle of an alarm mask read.
   sequence mask_rd_s;
      psel_in && penable_in && pready_out && !pwrite_in && paddr_in == 8'h1c;
   endsequence
   wake_gate_a:
      assert property (wake_out == (irq_out & clk_in_shutdown_in)) else $error("wake gating wrong");
   wake_quiet_a:
      assert property (shutdown_wake_in |=> !irq_out) else $error("irq after wake");
   stall_cause_a:
      assert property (!pready_out |-> psel_in && penable_in) else $error("stray wait state");
   stall_bound_a:
      assert property (stall_s |-> ##[1:100] pready_out) else $error("stall never ends");
   read_sync_a:
      assert property (cnt_rd_s |-> !pready_out) else $error("count read not crossed");
   mask_upper_a:
      assert property (mask_rd_s |-> prdata_out[31:3] == 29'h0) else $error("mask upper bits set");
   unmapped_zero_a:
      assert property (pslverr_out && !pwrite_in |-> prdata_out == 32'h0) else $error("bad read data");
   evt_pulse_a:
      assert property (evt_out |=> !evt_out) else $error("event too long");
endmodule
bind rsa_core rsa_core_chk #(.CS_DIV(CS_DIV)) u_chk (
   .ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
   .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
   .shutdown_wake_in(shutdown_wake_in), .clk_in_shutdown_in(clk_in_shutdown_in),
   .dbg_halt_in(dbg_halt_in), .irq_out(irq_out), .wake_out(wake_out), .evt_out(evt_out));

// ---- verification/rsa_core_tb.sv ----
/* Self-checking bench for rsa_core over APB.
   Assumes CS_DIV of 4 so crossings stay short. */
`timescale 1ns/1ps
module rsa_core_tb;
   logic        ref_clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        psel_in = 1'b0;
   logic        penable_in = 1'b0;
   logic        pwrite_in = 1'b0;
   logic [7:0]  paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0;
   logic        shutdown_wake_in = 1'b0;
   logic        clk_in_shutdown_in = 1'b0;
   wire  [31:0] prdata_out;
   wire         pready_out;
   wire         pslverr_out;
   wire         irq_out;
   wire         wake_out;
   wire         evt_out;
   logic [31:0] d;
   logic        err;
   int          num_errors = 0;
   int          tests_run = 0;
   int          cyc = 0;
   rsa_core #(.CS_DIV(4)) u_dut (
      .ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .shutdown_wake_in(shutdown_wake_in), .clk_in_shutdown_in(clk_in_shutdown_in),
      .dbg_halt_in(1'b0), .irq_out(irq_out), .wake_out(wake_out), .evt_out(evt_out));
   // Free-running 250 MHz clock.
   always #2 ref_clk_in = ~ref_clk_in;
   // One APB transfer; it holds the request until pready is seen at an edge or 300 edges have passed.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge ref_clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= wd;
      @(posedge ref_clk_in);
      penable_in <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 300);
      if (pready_out !== 1'b1) begin
         num_errors++;
         $display("BAD %0t no pready", $time);
      end
      d = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   // Word and flag comparisons.
   task chk32(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task chk1(input logic got, input logic exp);
      chk32({31'h0, got}, {31'h0, exp});
   endtask
   // Polls the status word until no crossing is pending, with a bounded count.
   task wait_idle;
      int k;
      k = 0;
      do begin
         apb(1'b0, 8'h14, 32'h0);
         k++;
      end while (d[7] !== 1'b0 && k < 50);
      if (d[7] !== 1'b0) begin
         num_errors++;
         $display("BAD %0t crossing stuck", $time);
      end
   endtask
   task wake_pulse;
      @(posedge ref_clk_in);
      shutdown_wake_in <= 1'b1;
      @(posedge ref_clk_in);
      shutdown_wake_in <= 1'b0;
   endtask
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Cuts a hang short; the whole run needs well under a thousand cycles.
   always @(posedge ref_clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (16) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      apb(1'b0, 8'h1c, 32'h0); chk32(d, 32'h0);
      chk1(irq_out, 1'b0);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, 8'h1c, i);
         apb(1'b0, 8'h1c, 32'h0); chk32(d, i);
      end
      apb(1'b1, 8'h1c, 32'h5);
      apb(1'b1, 8'h1c, 32'h6);
      apb(1'b0, 8'h1c, 32'h0); chk32(d, 32'h6);
      apb(1'b1, 8'h1c, 32'hff);
      apb(1'b0, 8'h1c, 32'h0); chk32(d, 32'h7);
      apb(1'b1, 8'h1c, 32'h3);
      apb(1'b0, 8'h14, 32'h0); chk32(d & 32'h80, 32'h80);
      wait_idle();
      apb(1'b0, 8'h10, 32'h0); chk32(d, 32'h81);
      apb(1'b1, 8'h10, 32'h80);
      apb(1'b0, 8'h10, 32'h0); chk32(d, 32'h1);
      $display("mask test done");
      apb(1'b1, 8'h20, 32'h5);
      apb(1'b0, 8'h20, 32'h0); chk32(d, 32'h5);
      apb(1'b1, 8'h24, 32'h1234);
      apb(1'b0, 8'h24, 32'h0); chk32(d, 32'h1234);
      apb(1'b0, 8'h3c, 32'h0); chk32(d, 32'h0);
      chk1(err, 1'b1);
      $display("sync test done");
      apb(1'b1, 8'h28, 32'h3);
      apb(1'b1, 8'h20, 32'h0);
      apb(1'b1, 8'h38, 32'h1);
      apb(1'b1, 8'h00, 32'h2);
      wait_idle();
      apb(1'b0, 8'h00, 32'h0); chk32(d, 32'h2);
      err = 1'b0;
      for (int k = 0; k < 200 && !err; k++) begin
         @(posedge ref_clk_in);
         err = (evt_out === 1'b1);
      end
      chk1(err, 1'b1);
      apb(1'b1, 8'h00, 32'h1);
      wait_idle();
      apb(1'b0, 8'h00, 32'h0); chk32(d, 32'h0);
      apb(1'b0, 8'h1c, 32'h0); chk32(d, 32'h0);
      $display("control test done");
      apb(1'b1, 8'h18, 32'h1);
      apb(1'b1, 8'h04, 32'h1);
      apb(1'b0, 8'h18, 32'h0); chk32(d, 32'h1);
      apb(1'b0, 8'h04, 32'h0); chk32(d, 32'h1);
      apb(1'b1, 8'h0c, 32'h80);
      apb(1'b1, 8'h1c, 32'h4);
      wait_idle();
      chk1(irq_out, 1'b1);
      clk_in_shutdown_in <= 1'b1;
      @(posedge ref_clk_in);
      @(posedge ref_clk_in);
      chk1(wake_out, 1'b1);
      wake_pulse();
      apb(1'b0, 8'h10, 32'h0); chk32(d, 32'h0);
      apb(1'b0, 8'h0c, 32'h0); chk32(d, 32'h0);
      apb(1'b0, 8'h1c, 32'h0); chk32(d, 32'h4);
      apb(1'b0, 8'h18, 32'h0); chk32(d, 32'h0);
      apb(1'b0, 8'h04, 32'h0); chk32(d, 32'h0);
      apb(1'b1, 8'h1c, 32'h2);
      wake_pulse();
      apb(1'b0, 8'h14, 32'h0); chk32(d & 32'h80, 32'h80);
      wait_idle();
      // Interrupts come back only after the controller would be set up.
      apb(1'b1, 8'h0c, 32'h80);
      @(posedge ref_clk_in);
      chk1(irq_out, 1'b1);
      $display("wake test done");
      tally_and_finish();
   end
endmodule

// ---- verilog/rsa_core.v ----
/*
 Clock block register interface: APB slave, request/acknowledge
 crossing to the counter side, shutdown wake handling, alarm mask.
 Assumes one clock; the counter side advances on a divided enable.
*/
// Local design decision: the APB register port.
// Operation
// RULE1 - Enabled interrupt sources wake from shutdown
// RULE2 - Wake keeps registers except four cleared ones
// RULE3 - Wake clears interrupt enables to zero
// RULE4 - Software sets interrupt controller before enabling
// RULE5 - Status still shows state after wake
// RULE6 - Enabled periodic event reaches event output
// RULE7 - Pending bit set at start, cleared done
// RULE8 - Completion raises sync done flag
// RULE9 - Access during pending stalls bus, completes
// RULE10 - Reset and enable writes pass crossing
// RULE11 - Value register writes cross to counter
// RULE12 - Counter and calendar reads cross back
// RULE13 - Alarm mask at 0x1c, resets zero
// RULE14 - Mask code selects matched calendar fields
// RULE15 - Mask upper bits read as zero
// RULE16 - Toggle handshake with double-flop synchronizers
`timescale 1ns/1ps
`include "rsa_defs.vh"

module rsa_core #(
   parameter CS_DIV = `RSA_CS_DIV
) (
   input  wire        ref_clk_in,
   input  wire        rst_in,
   input  wire        psel_in,
   input  wire        penable_in,
   input  wire        pwrite_in,
   input  wire [7:0]  paddr_in,
   input  wire [31:0] pwdata_in,
   output reg  [31:0] prdata_out,
   output wire        pready_out,
   output wire        pslverr_out,
   input  wire        shutdown_wake_in,
   input  wire        clk_in_shutdown_in,
   input  wire        dbg_halt_in,
   output wire        irq_out,
   output wire        wake_out,
   output reg         evt_out
);

   // Bus-side state.
   reg  [7:0]  inten;         // Interrupt enables.
   reg  [7:0]  flags;         // Sticky interrupt flags.
   reg         rdreq;         // Read request control bit.
   reg         dbg_run;       // Keep counting while halted.
   reg         ev_en;         // Overflow event output enable.
   reg         pending;       // Crossing in flight.
   reg         req_tgl;       // Request toggle.
   reg         op_wr;         // Held operation: write or read.
   reg  [2:0]  op_idx;        // Held target index.
   reg  [31:0] op_dat;        // Held write data.
   reg         rd_wait;       // Read sync launched.
   reg         rd_rdy;        // Read data loaded.
   reg         ak1, ak2;      // Acknowledge synchronizer.
   reg  [1:0]  ev1, ev2, ev3; // Event toggle synchronizer.
   reg  [31:0] sh [0:7];      // Bus-side copies for readback.

   // Counter-side state.
   reg  [31:0] cs [0:7];      // Active counter-side registers.
   reg  [31:0] snap_cnt;      // Counter snapshot for reads.
   reg  [31:0] snap_clk;      // Calendar snapshot for reads.
   reg         rq1, rq2;      // Request synchronizer.
   reg         ack_tgl;       // Acknowledge toggle.
   reg  [1:0]  cs_ev;         // Event toggles: alarm, overflow.
   reg         match_d;       // Alarm match one tick ago.
   reg  [7:0]  div;           // Tick divider.
   wire        tick = (div == CS_DIV - 1);

   // Separate loop indexes keep each process the only writer of its own.
   integer i;                 // Bus-side loop index.
   integer j;                 // Counter-side loop index.

   // Address decode.
   wire acc = psel_in & penable_in;
   wire win = (paddr_in[7:5] == 3'h1) & (paddr_in[4:2] < 3'h6)
            & (paddr_in[1:0] == 2'h0);
   wire [2:0] a_idx = (paddr_in == `RSA_MASK) ? `RSA_I_MASK :
                      (paddr_in == `RSA_CTRL) ? `RSA_I_CTRL :
                      paddr_in[4:2];
   wire is_rsync = ~pwrite_in & win & (paddr_in[4:2] < 3'h2); // see RULE12
   wire is_wsync = pwrite_in & (win | paddr_in == `RSA_MASK
                 | paddr_in == `RSA_CTRL); // see RULE10 see RULE11
   wire sync_acc = acc & (is_rsync | is_wsync);
   wire mapped = win | (paddr_in <= `RSA_EVCTRL && paddr_in[1:0] == 2'h0);

   // A write completes at launch; a read waits for its snapshot.
   // A synchronized access finding the crossing busy is held off.
   assign pready_out = ~sync_acc | (pwrite_in ? ~pending : rd_rdy); // see RULE9
   assign pslverr_out = acc & pready_out & ~mapped;
   wire launch = sync_acc & ~pending & (pwrite_in | ~rd_wait);
   wire done = pending & (ak2 == req_tgl);
   wire wr_ok = acc & pready_out & pwrite_in & mapped;

   // Interrupts double as wake sources; wake needs a live counter clock.
   assign irq_out = |(flags & inten);                 // see RULE1
   assign wake_out = irq_out & clk_in_shutdown_in;    // see RULE1

   // Events seen on the bus side: edges of the synchronized toggles.
   // A toggle crosses cleanly where a short pulse from the slow side could be lost.
   wire [1:0] ev_hit = ev2 ^ ev3;

   // Bus-side process: register writes, crossing launch and completion.
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         inten <= 8'h00;
         flags <= 8'h00;
         rdreq <= 1'b0;
         dbg_run <= 1'b0;
         ev_en <= 1'b0;
         pending <= 1'b0;
         req_tgl <= 1'b0;
         op_wr <= 1'b0;
         op_idx <= 3'h0;
         op_dat <= 32'h0;
         rd_wait <= 1'b0;
         rd_rdy <= 1'b0;
         ak1 <= 1'b0;
         ak2 <= 1'b0;
         ev1 <= 2'h0;
         ev2 <= 2'h0;
         ev3 <= 2'h0;
         evt_out <= 1'b0;
         prdata_out <= 32'h0;
         for (i = 0; i < 8; i = i + 1) begin
            sh[i] <= 32'h0;
         end
      end else begin
         ak1 <= ack_tgl;            // see RULE16
         ak2 <= ak1;
         ev1 <= cs_ev;
         ev2 <= ev1;
         ev3 <= ev2;
         // A periodic event only leaves the block when enabled.
         evt_out <= ev_en & ev_hit[`RSA_F_OVF]; // see RULE6

         // Launch: pending rises at once, request toggles.
         if (launch) begin
            pending <= 1'b1;        // see RULE7
            req_tgl <= ~req_tgl;    // see RULE16
            op_wr <= pwrite_in;
            op_idx <= a_idx;
            op_dat <= pwdata_in;
            rd_wait <= ~pwrite_in;
            if (pwrite_in) begin
               // Mask keeps only the select field.
               sh[a_idx] <= (a_idx == `RSA_I_MASK) ?
                  {29'h0, pwdata_in[2:0]} : pwdata_in; // see RULE15
            end
         end else if (done) begin
            pending <= 1'b0;        // see RULE7
         end

         // Read snapshot arrives with completion.
         if (done & rd_wait) begin
            prdata_out <= (op_idx == `RSA_I_COUNT) ? snap_cnt : snap_clk;
            rd_rdy <= 1'b1;
         end else if (acc & rd_rdy) begin
            rd_rdy <= 1'b0;
            rd_wait <= 1'b0;
         end else if (psel_in & ~penable_in) begin
            // Setup phase: capture ordinary read data.
            case (paddr_in)
               `RSA_CTRL:   prdata_out <= {30'h0, sh[`RSA_I_CTRL][`RSA_EN], 1'b0};
               `RSA_RDREQ:  prdata_out <= {31'h0, rdreq};
               `RSA_IENCLR: prdata_out <= {24'h0, inten};
               `RSA_IENSET: prdata_out <= {24'h0, inten};
               `RSA_IFLAG:  prdata_out <= {24'h0, flags};
               `RSA_STATUS: prdata_out <= {24'h0, pending, 7'h0}; // see RULE5
               `RSA_DBG:    prdata_out <= {31'h0, dbg_run};
               `RSA_EVCTRL: prdata_out <= {31'h0, ev_en};
               default:     prdata_out <= win ? sh[a_idx] :
                  (paddr_in == `RSA_MASK) ? sh[`RSA_I_MASK] : 32'h0;
            endcase
         end

         // Plain writes; set wins over a clear of the same flag bit.
         if (wr_ok) begin
            case (paddr_in)
               `RSA_RDREQ:  rdreq <= pwdata_in[0];
               `RSA_IENCLR: inten <= inten & ~pwdata_in[7:0];
               `RSA_IENSET: inten <= inten | pwdata_in[7:0]; // see RULE4
               `RSA_IFLAG:  flags <= flags & ~pwdata_in[7:0];
               `RSA_DBG:    dbg_run <= pwdata_in[0];
               `RSA_EVCTRL: ev_en <= pwdata_in[0];
               default:     ;
            endcase
         end
         if (done) begin
            flags[`RSA_F_SYNC] <= 1'b1;    // see RULE8
         end
         if (ev_hit[`RSA_F_ALARM]) begin
            flags[`RSA_F_ALARM] <= 1'b1;
         end
         if (ev_hit[`RSA_F_OVF]) begin
            flags[`RSA_F_OVF] <= 1'b1;
         end

         // Software reset lands only once it has crossed.
         if (done & op_wr & op_idx == `RSA_I_CTRL & op_dat[`RSA_SOFT_RESET_CTL]) begin
            inten <= 8'h00;
            flags <= 8'h00;
            rdreq <= 1'b0;
            ev_en <= 1'b0;
            for (i = 0; i < 8; i = i + 1) begin
               sh[i] <= 32'h0;     // see RULE10
            end
         end

         // Shutdown wake: these four return to reset, all else stays.
         // The pending bit in status keeps showing the block's state.
         if (shutdown_wake_in) begin
            inten <= 8'h00;         // see RULE2 see RULE3
            flags <= 8'h00;         // see RULE2
            rdreq <= 1'b0;          // see RULE2
            dbg_run <= 1'b0;        // see RULE2
         end
      end
   end

   // Alarm match: each select code adds one calendar field.
   // Seconds 5:0, minutes 11:6, hours 16:12, days 21:17,
   // months 25:22, years 31:26. The reserved code never matches.
   reg [31:0] fmask;
   always @* begin
      case (cs[`RSA_I_MASK][2:0])      // see RULE14
         3'h1:    fmask = 32'h0000003f;
         3'h2:    fmask = 32'h00000fff;
         3'h3:    fmask = 32'h0001ffff;
         3'h4:    fmask = 32'h003fffff;
         3'h5:    fmask = 32'h03ffffff;
         3'h6:    fmask = 32'hffffffff;
         default: fmask = 32'h00000000;
      endcase
   end
   wire sel_on = (cs[`RSA_I_MASK][2:0] != `RSA_SEL_OFF)
               & (cs[`RSA_I_MASK][2:0] != `RSA_SEL_RSV);
   wire match = sel_on
      & (((cs[`RSA_I_CLOCK] ^ cs[4]) & fmask) == 32'h0); // see RULE14
   wire run = cs[`RSA_I_CTRL][`RSA_EN] & (~dbg_halt_in | dbg_run);

   // Counter-side process: advances only on the divided tick, so it
   // behaves as a slow domain. The request is sampled twice before use.
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         div <= 8'h00;
         rq1 <= 1'b0;
         rq2 <= 1'b0;
         ack_tgl <= 1'b0;
         cs_ev <= 2'h0;
         match_d <= 1'b0;
         snap_cnt <= 32'h0;
         snap_clk <= 32'h0;
         for (j = 0; j < 8; j = j + 1) begin
            cs[j] <= 32'h0;         // see RULE13
         end
      end else begin
         div <= tick ? 8'h00 : div + 8'h01;
         if (tick) begin
            rq1 <= req_tgl;         // see RULE16
            rq2 <= rq1;
            match_d <= match;
            if (match & ~match_d) begin
               cs_ev[`RSA_F_ALARM] <= ~cs_ev[`RSA_F_ALARM];
            end
            // Free running counter, wrapping at the period.
            if (run) begin
               if (cs[`RSA_I_COUNT] == cs[`RSA_I_PER]) begin
                  cs[`RSA_I_COUNT] <= 32'h0;
                  cs_ev[`RSA_F_OVF] <= ~cs_ev[`RSA_F_OVF];
               end else begin
                  cs[`RSA_I_COUNT] <= cs[`RSA_I_COUNT] + 32'h1;
               end
            end
            // Carry out the held operation, then acknowledge.
            if (rq2 != ack_tgl) begin
               ack_tgl <= rq2;      // see RULE16
               if (~op_wr) begin
                  snap_cnt <= cs[`RSA_I_COUNT]; // see RULE12
                  snap_clk <= cs[`RSA_I_CLOCK];
               end else if (op_idx == `RSA_I_CTRL & op_dat[`RSA_SOFT_RESET_CTL]) begin
                  for (j = 0; j < 8; j = j + 1) begin
                     cs[j] <= 32'h0;   // see RULE10
                  end
               end else if (op_idx == `RSA_I_MASK) begin
                  cs[op_idx] <= {29'h0, op_dat[2:0]}; // see RULE15
               end else begin
                  cs[op_idx] <= op_dat;  // see RULE11
               end
            end
         end
      end
   end

endmodule

// ---- verilog/rsa_defs.vh ----
/*
 Register offsets, field positions and reset values of the clock block.
 Assumes a byte-addressed APB with 32-bit words.
*/
`ifndef RSA_DEFS_VH
`define RSA_DEFS_VH

// Byte offsets of the registers.
`define RSA_CTRL     8'h00
`define RSA_RDREQ    8'h04
`define RSA_IENCLR   8'h08
`define RSA_IENSET   8'h0c
`define RSA_IFLAG    8'h10
`define RSA_STATUS   8'h14
`define RSA_DBG      8'h18
`define RSA_MASK     8'h1c
`define RSA_COUNT    8'h20
`define RSA_CLOCK    8'h24
`define RSA_PER      8'h28
`define RSA_COMP     8'h2c
`define RSA_ALARM    8'h30
`define RSA_FREQ     8'h34
`define RSA_EVCTRL   8'h38

// Indexes of the synchronized registers.
`define RSA_I_COUNT  3'h0
`define RSA_I_CLOCK  3'h1
`define RSA_I_PER    3'h2
`define RSA_I_MASK   3'h6
`define RSA_I_CTRL   3'h7

// Field positions.
`define RSA_SOFT_RESET_CTL    0
`define RSA_EN       1
`define RSA_F_ALARM  0
`define RSA_F_OVF    1
`define RSA_F_SYNC   7
`define RSA_S_PEND   7

// Reset values, alarm mask codes and the default tick divider.
`define RSA_MASK_RST 3'h0
`define RSA_SEL_OFF  3'h0
`define RSA_SEL_RSV  3'h7
`define RSA_CS_DIV   8

`endif
